// >>> rtl/pdc_pkg.sv
/*
  Constants for one paced DMA channel: register offsets, control
  field positions, reset values, width and select codes and state codes.
  Assumes an APB master on the subsystem clock and a word-wide memory port.
*/
`default_nettype none
package pdc_pkg;
  // -------------------------------------------------------------------
  // register offsets (byte addresses)
  // -------------------------------------------------------------------
  localparam int          PDC_AW          = 8;
  localparam logic [7:0]  PDC_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  PDC_OFF_STAT    = 8'h04;
  localparam logic [7:0]  PDC_OFF_A_SRC   = 8'h08;
  localparam logic [7:0]  PDC_OFF_A_DST   = 8'h0C;
  localparam logic [7:0]  PDC_OFF_A_CNT   = 8'h10;
  localparam logic [7:0]  PDC_OFF_B_SRC   = 8'h14;
  localparam logic [7:0]  PDC_OFF_B_DST   = 8'h18;
  localparam logic [7:0]  PDC_OFF_B_CNT   = 8'h1C;
  localparam logic [7:0]  PDC_OFF_RATIO   = 8'h20;
  localparam logic [7:0]  PDC_OFF_BUFSTAT = 8'h24;
  // -------------------------------------------------------------------
  // control word fields
  // -------------------------------------------------------------------
  localparam int PDC_C_PSEL_LO  = 23;
  localparam int PDC_C_PSEL_HI  = 26;
  localparam int PDC_C_WAIT_LO  = 14;
  localparam int PDC_C_WAIT_HI  = 21;
  localparam int PDC_C_DSTEP_LO = 12;
  localparam int PDC_C_SSTEP_LO = 10;
  localparam int PDC_C_HIGH     = 9;
  localparam int PDC_C_CLR_B    = 8;
  localparam int PDC_C_CLR_A    = 7;
  localparam int PDC_C_IRQEN    = 6;
  localparam int PDC_C_RESET    = 5;
  localparam int PDC_C_PAUSE    = 4;
  localparam int PDC_C_WIDTH_LO = 2;
  localparam int PDC_C_DIR      = 1;
  localparam int PDC_C_PERIPH   = 0;
  // storable bits: every defined field bit but the three self-clearing ones
  localparam logic [31:0] PDC_CTRL_MASK  = 32'h07BFFE5F;
  localparam logic [31:0] PDC_CTRL_RST   = 32'h00000000;
  localparam int          PDC_CNT_W      = 16;
  localparam int          PDC_WAIT_W     = 8;
  localparam int          PDC_RATIO_W    = 8;
  // -------------------------------------------------------------------
  // codes
  // -------------------------------------------------------------------
  localparam logic [1:0] PDC_WID_BYTE = 2'h0;
  localparam logic [1:0] PDC_WID_HALF = 2'h1;
  localparam logic [1:0] PDC_WID_WORD = 2'h2;
  localparam logic [3:0] PDC_SEL_SER_RX = 4'h4;
  localparam logic [3:0] PDC_SEL_SER_TX = 4'h5;
  typedef enum logic [1:0] {
    PDC_ST_IDLE  = 2'b00,
    PDC_ST_READ  = 2'b01,
    PDC_ST_WRITE = 2'b10
  } pdc_state_type;
endpackage : pdc_pkg
`default_nettype wire

// >>> rtl/pdc_channel.sv
/*
  One paced DMA channel with two buffer descriptors, APB register slave,
  memory access port, paced ready selection and completion interrupt.
  Assumes memory port ack comes from logic on pclk; ready lines are async.
*/
`default_nettype none
module pdc_channel
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [PDC_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // memory access port
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [31:0]            mem_addr,
  output logic [1:0]             mem_size,
  output logic [31:0]            mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  // out-of-band peripheral ready lines
  input  wire logic              serial_rx_avail,
  input  wire logic              serial_tx_room,
  input  wire logic [1:0]        fabric_ready_port0,
  input  wire logic [1:0]        fabric_ready_port1,
  input  wire logic              comm_unit_rx_avail,
  input  wire logic              comm_unit_tx_room,
  // arbitration
  input  wire logic              high_class_req,
  output logic                   high_rank,
  // interrupt
  output logic                   dma_irq
);
  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  logic [31:0]            ctrl_r;
  logic [31:0]            src_a_r, dst_a_r, src_b_r, dst_b_r;
  logic [PDC_CNT_W-1:0]   cnt_a_r, cnt_b_r;
  logic [PDC_RATIO_W-1:0] ratio_r, opp_r;
  logic                   done_a_r, done_b_r, buf_sel_r;
  logic [PDC_WAIT_W-1:0]  wait_r;
  logic [7:0]             rdy_s1_r, rdy_s2_r;
  pdc_state_type          state_r;

  // -------------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------------
  wire        acc     = psel & penable;
  wire        wr_fire = acc & pready & pwrite;
  wire        hit_ctrl  = paddr == PDC_OFF_CTRL;
  wire        hit_stat  = paddr == PDC_OFF_STAT;
  wire        hit_asrc  = paddr == PDC_OFF_A_SRC;
  wire        hit_adst  = paddr == PDC_OFF_A_DST;
  wire        hit_acnt  = paddr == PDC_OFF_A_CNT;
  wire        hit_bsrc  = paddr == PDC_OFF_B_SRC;
  wire        hit_bdst  = paddr == PDC_OFF_B_DST;
  wire        hit_bcnt  = paddr == PDC_OFF_B_CNT;
  wire        hit_ratio = paddr == PDC_OFF_RATIO;
  wire        hit_bstat = paddr == PDC_OFF_BUFSTAT;
  wire        hit_any   = hit_ctrl | hit_stat | hit_asrc | hit_adst |
                          hit_acnt | hit_bsrc | hit_bdst | hit_bcnt |
                          hit_ratio | hit_bstat;
  wire        wr_ctrl   = wr_fire & hit_ctrl;
  wire        chan_rst  = wr_ctrl & pwdata[PDC_C_RESET];
  wire        clr_a     = wr_ctrl & pwdata[PDC_C_CLR_A];
  wire        clr_b     = wr_ctrl & pwdata[PDC_C_CLR_B];
  wire        wr_acnt   = wr_fire & hit_acnt;
  wire        wr_bcnt   = wr_fire & hit_bcnt;

  // shared status: done flag with select indication clear
  wire [1:0]  bufstat   = {done_b_r & ~buf_sel_r,
                           done_a_r & ~buf_sel_r};
  // self-clearing bits are never stored, so they read back as zero
  wire [31:0] rd_mux =
      hit_ctrl  ? ctrl_r :
      hit_stat  ? {29'h0, buf_sel_r, done_b_r, done_a_r} :
      hit_asrc  ? src_a_r :
      hit_adst  ? dst_a_r :
      hit_acnt  ? {16'h0, cnt_a_r} :
      hit_bsrc  ? src_b_r :
      hit_bdst  ? dst_b_r :
      hit_bcnt  ? {16'h0, cnt_b_r} :
      hit_ratio ? {24'h0, ratio_r} :
      hit_bstat ? {30'h0, bufstat} : 32'h00000000;

  // -------------------------------------------------------------------
  // control fields
  // -------------------------------------------------------------------
  wire [3:0]  psel_code = ctrl_r[PDC_C_PSEL_HI:PDC_C_PSEL_LO];
  wire [PDC_WAIT_W-1:0] wait_cfg =
      ctrl_r[PDC_C_WAIT_HI:PDC_C_WAIT_LO];
  wire [1:0]  dstep     = ctrl_r[PDC_C_DSTEP_LO+1:PDC_C_DSTEP_LO];
  wire [1:0]  sstep     = ctrl_r[PDC_C_SSTEP_LO+1:PDC_C_SSTEP_LO];
  wire [1:0]  width     = ctrl_r[PDC_C_WIDTH_LO+1:PDC_C_WIDTH_LO];
  wire        periph    = ctrl_r[PDC_C_PERIPH];
  wire        dir_out   = ctrl_r[PDC_C_DIR];
  wire        paused    = ctrl_r[PDC_C_PAUSE];
  wire        irq_en    = ctrl_r[PDC_C_IRQEN];
  wire        hi_flag   = ctrl_r[PDC_C_HIGH];

  // step code to byte count: 0, 1, 2, 4
  wire [31:0] src_inc = (sstep == 2'h3) ? 32'h4 : {30'h0, sstep};
  wire [31:0] dst_inc = (dstep == 2'h3) ? 32'h4 : {30'h0, dstep};
  wire        src_fix = periph & ~dir_out;
  wire        dst_fix = periph &  dir_out;
  // reserved width code falls back to byte so the port never sees it
  wire [1:0]  wid_eff = (width == 2'h3) ? PDC_WID_BYTE : width;

  // -------------------------------------------------------------------
  // peripheral ready selection
  // -------------------------------------------------------------------
  wire [7:0]  rdy_raw = {comm_unit_tx_room, comm_unit_rx_avail,
                         fabric_ready_port1[0], fabric_ready_port1[1],
                         fabric_ready_port0[0], fabric_ready_port0[1],
                         serial_tx_room, serial_rx_avail};
  wire        sel_ok  = (psel_code == PDC_SEL_SER_RX) |
                        (psel_code == PDC_SEL_SER_TX) |
                        (psel_code[3] & ~psel_code[1]
                                      & ~psel_code[2]) |
                        (psel_code[3] & psel_code[2]);
  wire [1:0]  sel_hi  = ~psel_code[3] ? 2'h0 :
                        ~psel_code[2] ? 2'h1 :
                        ~psel_code[1] ? 2'h2 : 2'h3;
  wire [2:0]  sel_idx = {sel_hi, psel_code[0]};
  wire        rdy_sel = sel_ok & rdy_s2_r[sel_idx];
  // memory to memory ignores ready and direction entirely
  wire        pace_ok = ~periph | (rdy_sel & (wait_r == '0));

  // -------------------------------------------------------------------
  // buffer choice and arbitration gate
  // -------------------------------------------------------------------
  wire [PDC_CNT_W-1:0] cur_cnt = buf_sel_r ? cnt_b_r : cnt_a_r;
  wire [PDC_CNT_W-1:0] oth_cnt = buf_sel_r ? cnt_a_r : cnt_b_r;
  wire        cur_live = cur_cnt != '0;
  wire        swap_buf = ~cur_live & (oth_cnt != '0);
  // a low channel yields ratio opportunities to pending high channels
  wire        arb_ok  = hi_flag | ~high_class_req | (opp_r >= ratio_r);
  wire        go      = (state_r == PDC_ST_IDLE) & cur_live & ~paused &
                        pace_ok & arb_ok;
  wire        rd_done = (state_r == PDC_ST_READ) & mem_ack;
  wire        wr_done = (state_r == PDC_ST_WRITE) & mem_ack;
  wire        last    = cur_cnt == 16'h0001;
  wire [31:0] cur_src = buf_sel_r ? src_b_r : src_a_r;
  wire [31:0] cur_dst = buf_sel_r ? dst_b_r : dst_a_r;
  wire [31:0] nxt_src = src_fix ? cur_src : cur_src + src_inc;
  wire [31:0] nxt_dst = dst_fix ? cur_dst : cur_dst + dst_inc;
  wire [PDC_CNT_W-1:0] nxt_cnt = cur_cnt - 16'h0001;
  wire        set_a   = wr_done & last & ~buf_sel_r;
  wire        set_b   = wr_done & last &  buf_sel_r;

  // -------------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (acc & ~pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~hit_any;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= PDC_CTRL_RST;
      ratio_r <= '0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= pwdata & PDC_CTRL_MASK;
      if (wr_fire & hit_ratio)
        ratio_r <= pwdata[PDC_RATIO_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      high_rank <= 1'b0;
    else
      high_rank <= ctrl_r[PDC_C_HIGH];
  end

  // -------------------------------------------------------------------
  // ready synchronisers
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_s1_r <= 8'h00;
      rdy_s2_r <= 8'h00;
    end else begin
      rdy_s1_r <= rdy_raw;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // -------------------------------------------------------------------
  // descriptors; a software write wins over the engine's own update
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_a_r <= 32'h00000000;
      dst_a_r <= 32'h00000000;
      src_b_r <= 32'h00000000;
      dst_b_r <= 32'h00000000;
    end else begin
      if (wr_done & ~buf_sel_r) begin
        src_a_r <= nxt_src;
        dst_a_r <= nxt_dst;
      end
      if (wr_done & buf_sel_r) begin
        src_b_r <= nxt_src;
        dst_b_r <= nxt_dst;
      end
      if (wr_fire & hit_asrc) src_a_r <= pwdata;
      if (wr_fire & hit_adst) dst_a_r <= pwdata;
      if (wr_fire & hit_bsrc) src_b_r <= pwdata;
      if (wr_fire & hit_bdst) dst_b_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_a_r <= '0;
      cnt_b_r <= '0;
    end else if (chan_rst) begin
      cnt_a_r <= '0;
      cnt_b_r <= '0;
    end else begin
      if (wr_done & ~buf_sel_r) cnt_a_r <= nxt_cnt;
      if (wr_done &  buf_sel_r) cnt_b_r <= nxt_cnt;
      if (wr_acnt) cnt_a_r <= pwdata[PDC_CNT_W-1:0];
      if (wr_bcnt) cnt_b_r <= pwdata[PDC_CNT_W-1:0];
    end
  end

  // -------------------------------------------------------------------
  // completion flags: set wins over clear
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_a_r <= 1'b0;
      done_b_r <= 1'b0;
    end else if (chan_rst) begin
      done_a_r <= 1'b0;
      done_b_r <= 1'b0;
    end else begin
      done_a_r <= set_a | (done_a_r & ~clr_a);
      done_b_r <= set_b | (done_b_r & ~clr_b);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dma_irq <= 1'b0;
    else
      dma_irq <= irq_en & (done_a_r | done_b_r);
  end

  // -------------------------------------------------------------------
  // transfer engine
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= PDC_ST_IDLE;
      buf_sel_r <= 1'b0;
      wait_r    <= '0;
      opp_r     <= '0;
    end else if (chan_rst) begin
      state_r   <= PDC_ST_IDLE;
      buf_sel_r <= 1'b0;
      wait_r    <= '0;
      opp_r     <= '0;
    end else begin
      if (wait_r != '0)
        wait_r <= wait_r - 8'h01;
      if (~hi_flag & high_class_req & ~arb_ok)
        opp_r <= opp_r + 8'h01;
      unique case (state_r)
        PDC_ST_IDLE: begin
          if (swap_buf)
            buf_sel_r <= ~buf_sel_r;
          if (go) begin
            state_r <= PDC_ST_READ;
            opp_r   <= '0;
          end
        end
        PDC_ST_READ: begin
          if (rd_done) begin
            state_r <= PDC_ST_WRITE;
          end
        end
        PDC_ST_WRITE: begin
          if (wr_done) begin
            state_r <= PDC_ST_IDLE;
            if (periph)
              wait_r <= wait_cfg;
            if (last)
              buf_sel_r <= ~buf_sel_r;
          end
        end
        default: state_r <= PDC_ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // memory port: request held until ack
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 32'h00000000;
      mem_size  <= PDC_WID_BYTE;
      mem_wdata <= 32'h00000000;
    end else if (chan_rst | wr_done) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
    end else if (go) begin
      mem_req   <= 1'b1;
      mem_we    <= 1'b0;
      mem_addr  <= cur_src;
      mem_size  <= wid_eff;
    end else if (rd_done) begin
      mem_we    <= 1'b1;
      mem_addr  <= cur_dst;
      mem_wdata <= mem_rdata;
    end
  end
endmodule // pdc_channel
`default_nettype wire

// >>> tb/pdc_channel_asserts.sv
/*
  Concurrent checks on the ports of one paced DMA channel.
  Assumes it is bound to every pdc_channel instance, one clock domain.
*/
`default_nettype none
module pdc_channel_asserts
  import pdc_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [PDC_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // memory port
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic [31:0]       mem_addr,
  input wire logic [1:0]        mem_size,
  input wire logic [31:0]       mem_wdata,
  input wire logic              mem_ack,
  input wire logic [31:0]       mem_rdata,
  // status
  input wire logic              high_rank,
  input wire logic              dma_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -------------------------------------------------------------------
  // helper decode
  // -------------------------------------------------------------------
  wire logic wr_ok;
  wire logic wr_ctrl;
  wire logic wr_cnt;
  wire logic ch_rst;
  logic      armed_r;
  assign wr_ok   = psel && penable && pready && pwrite;
  assign wr_ctrl = wr_ok && paddr == PDC_OFF_CTRL;
  assign wr_cnt  = wr_ok && (paddr == PDC_OFF_A_CNT || paddr == PDC_OFF_B_CNT)
                   && pwdata[15:0] != 16'h0000;
  // a channel reset may abort a request that was never acknowledged
  assign ch_rst  = wr_ctrl && pwdata[PDC_C_RESET];
  // only a non-zero count write may wake the engine
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) armed_r <= 1'b0;
    else if (wr_cnt) armed_r <= 1'b1;
  a_zero_idle: assert property (!armed_r |-> !mem_req)
    else $error("memory request before any count write");
  a_irq_off: assert property (wr_ctrl && !pwdata[PDC_C_IRQEN] |->
    ##2 !dma_irq)
    else $error("irq active with enable clear");
  a_rank_copy: assert property (wr_ctrl |-> ##2
    high_rank == $past(pwdata[PDC_C_HIGH], 2))
    else $error("high rank does not follow control");
  a_req_hold: assert property (mem_req && !mem_ack && !ch_rst |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  a_read_write: assert property (!ch_rst &&
    mem_req && !mem_we && mem_ack |=>
    mem_req && mem_we && mem_wdata == $past(mem_rdata))
    else $error("write phase missing or wrong data");
  a_idle_gap: assert property (mem_req && mem_we && mem_ack |=>
    !mem_req)
    else $error("no idle cycle after transfer");
  a_size_legal: assert property (mem_req |-> mem_size != 2'h3)
    else $error("reserved size issued");
  a_reset_quiet: assert property (wr_ctrl && pwdata[PDC_C_RESET]
    |=> !mem_req [*2])
    else $error("request after channel reset");
  c_reset: cover property (wr_ctrl && pwdata[PDC_C_RESET]);
  c_xfer: cover property (mem_req && mem_we && mem_ack);
  c_irq: cover property ($rose(dma_irq));
endmodule // pdc_channel_asserts
bind pdc_channel pdc_channel_asserts pdc_channel_asserts_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata,
  .mem_ack, .mem_rdata, .high_rank, .dma_irq);
`default_nettype wire

// >>> tb/pdc_mem_model.sv
/*
  Same-clock memory answering the channel's port after lat idle cycles.
  Assumes one request at a time; logs the last write for the bench.
*/
`default_nettype none
module pdc_mem_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [1:0]  mem_size,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // control and log
  input  wire logic [3:0]  lat,
  output var int           wr_n,
  output logic [31:0]      last_wa,
  output logic [31:0]      last_wd,
  output logic [1:0]       last_sz
);
  logic [3:0] wait_r;
  // read data toggles off-ack so a stale sample never looks right
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      wr_n <= 0;
      mem_rdata <= 32'h0;
    end else begin
      mem_rdata <= ~mem_rdata;
      if (mem_ack) begin
        mem_ack <= 1'b0;
        wait_r <= 4'h0;
      end else if (mem_req && wait_r >= lat) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_addr ^ 32'h5A5A0000;
      end else if (mem_req) wait_r <= wait_r + 4'h1;
      if (mem_ack && mem_req && mem_we) begin
        wr_n <= wr_n + 1;
        last_wa <= mem_addr;
        last_wd <= mem_wdata;
        last_sz <= mem_size;
      end
    end
endmodule // pdc_mem_model
`default_nettype wire

// >>> tb/test_peripheral_dma_channel.sv
/*
  Self-checking bench: APB master, memory model and ready lines.
  Assumes package, design, checker and model are compiled first.
*/
`default_nettype none
module test_peripheral_dma_channel import pdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic              pclk, presetn, psel, penable, pwrite, hcr, e_r;
  logic [PDC_AW-1:0] paddr;
  logic [31:0]       pwdata, q;
  logic [7:0]        rdyv;
  logic [3:0]        lat;
  wire logic [31:0]  prdata, mem_addr, mem_wdata, mem_rdata, last_wa, last_wd;
  wire logic         pready, pslverr, mem_req, mem_we, mem_ack;
  wire logic         high_rank, dma_irq;
  wire logic [1:0]   mem_size, last_sz;
  int                wr_n, n_errors = 0, n_checks = 0, cyc = 0;
  pdc_channel pdc_channel_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we,
    .mem_addr, .mem_size, .mem_wdata, .mem_ack, .mem_rdata,
    .serial_rx_avail(rdyv[0]), .serial_tx_room(rdyv[1]),
    .fabric_ready_port0(rdyv[3:2]), .fabric_ready_port1(rdyv[5:4]),
    .comm_unit_rx_avail(rdyv[6]), .comm_unit_tx_room(rdyv[7]),
    .high_class_req(hcr), .high_rank, .dma_irq);
  pdc_mem_model pdc_mem_model_inst (.pclk, .presetn, .mem_req, .mem_we,
    .mem_addr, .mem_size, .mem_wdata, .mem_ack, .mem_rdata, .lat, .wr_n,
    .last_wa, .last_wd, .last_sz);
  // -------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic wait_idle(input logic [7:0] a);
    do apb(1'b0, a, 32'h0); while (q !== 32'h0);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 10; i++) rd(8'(i * 4), "reset", 32'h0);
    rd(8'h40, "unmapped", 32'h0);
    chk("slverr", {31'h0, e_r}, 32'h1);
    apb(1'b1, PDC_OFF_CTRL, 32'hFFFFFFFF);
    rd(PDC_OFF_CTRL, "ctrl", 32'h07BFFE5F);
    apb(1'b1, PDC_OFF_A_CNT, 32'h5);
    rd(PDC_OFF_A_CNT, "held", 32'h5);
    apb(1'b1, PDC_OFF_CTRL, 32'h20);
    rd(PDC_OFF_A_CNT, "ch_reset", 32'h0);
  endtask
  task automatic t_m2m;
    apb(1'b1, PDC_OFF_A_SRC, 32'h100);
    apb(1'b1, PDC_OFF_A_DST, 32'h200);
    apb(1'b1, PDC_OFF_CTRL, 32'h3E5A);
    apb(1'b1, PDC_OFF_A_CNT, 32'h3);
    repeat (15) @(posedge pclk);
    rd(PDC_OFF_A_CNT, "paused", 32'h3);
    chk("rank", {31'h0, high_rank}, 32'h1);
    rd(PDC_OFF_CTRL, "ctrl_rmw", 32'h3E5A);
    apb(1'b1, PDC_OFF_CTRL, q & ~32'h10);
    wait_idle(PDC_OFF_A_CNT);
    chk("writes", 32'(wr_n), 32'h3);
    chk("wd", last_wd, 32'h108 ^ 32'h5A5A0000);
    chk("wa", last_wa, 32'h208);
    chk("sz", {30'h0, last_sz}, 32'h2);
    rd(PDC_OFF_A_SRC, "src", 32'h10C);
    rd(PDC_OFF_A_DST, "dst", 32'h20C);
    rd(PDC_OFF_STAT, "stat", 32'h5);
    chk("irq", {31'h0, dma_irq}, 32'h1);
    apb(1'b1, PDC_OFF_CTRL, 32'h3ECA);
    rd(PDC_OFF_STAT, "clr_a", 32'h4);
    chk("irq_a", {31'h0, dma_irq}, 32'h0);
    lat <= 4'h2;
    apb(1'b1, PDC_OFF_RATIO, 32'h14);
    apb(1'b1, PDC_OFF_B_SRC, 32'h300);
    apb(1'b1, PDC_OFF_B_DST, 32'h400);
    // reserved width code: the port must still see a byte access
    apb(1'b1, PDC_OFF_CTRL, 32'h244C);
    hcr <= 1'b1;
    apb(1'b1, PDC_OFF_B_CNT, 32'h2);
    rd(PDC_OFF_B_CNT, "arb_wait", 32'h2);
    wait_idle(PDC_OFF_B_CNT);
    hcr <= 1'b0;
    rd(PDC_OFF_B_SRC, "src_b", 32'h302);
    rd(PDC_OFF_B_DST, "dst_b", 32'h404);
    chk("sz_b", {30'h0, last_sz}, 32'h0);
    rd(PDC_OFF_STAT, "stat_b", 32'h2);
    rd(PDC_OFF_BUFSTAT, "buf", 32'h2);
    apb(1'b1, PDC_OFF_CTRL, 32'h254C);
    rd(PDC_OFF_STAT, "clr_b", 32'h0);
    rd(PDC_OFF_BUFSTAT, "buf_clr", 32'h0);
    chk("irq_b", {31'h0, dma_irq}, 32'h0);
  endtask
  task automatic t_periph;
    logic [3:0]  code [8] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF};
    int          bit_of [8] = '{0, 1, 3, 2, 5, 4, 6, 7};
    logic [31:0] c;
    int          g;
    lat <= 4'h3;
    for (int i = 0; i < 8; i++) begin
      c = {5'h0, code[i], 1'b0, 8'h06, 4'hF, 6'h0, 2'h2, code[i][0], 1'b1};
      rdyv <= ~(8'h01 << bit_of[i]);
      apb(1'b1, PDC_OFF_A_SRC, 32'h1000);
      apb(1'b1, PDC_OFF_A_DST, 32'h2000);
      apb(1'b1, PDC_OFF_CTRL, c);
      apb(1'b1, PDC_OFF_A_CNT, 32'h2);
      repeat (12) @(posedge pclk);
      rd(PDC_OFF_A_CNT, "not_ready", 32'h2);
      rdyv <= 8'h01 << bit_of[i];
      while (mem_req !== 1'b1) @(posedge pclk);
      while (mem_req === 1'b1) @(posedge pclk);
      g = 0;
      while (mem_req !== 1'b1) begin
        g++;
        @(posedge pclk);
      end
      chk("gap", 32'(g >= 6), 32'h1);
      wait_idle(PDC_OFF_A_CNT);
      rd(PDC_OFF_A_SRC, "src_p", code[i][0] ? 32'h1008 : 32'h1000);
      rd(PDC_OFF_A_DST, "dst_p", code[i][0] ? 32'h2000 : 32'h2008);
    end
  endtask
  // -------------------------------------------------------------------
  // clock, timeout and main sequence
  // -------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_sim;
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rdyv = '0;
    lat = 4'h0;
    hcr = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_m2m;
    t_periph;
    end_sim;
  end
endmodule // test_peripheral_dma_channel
`default_nettype wire
